// ==== core/pwds_lvl_mem.sv ====
/*
  Sixteen 8-bit level magnitudes, one write port and a registered read.
  Assumes writes come from the register port and reads from the loader.
*/
`timescale 1ns/10ps
`default_nettype none
module pwds_lvl_mem (
  input  wire logic       hclk,    // Clock
  input  wire logic       hresetn, // Async reset, low
  input  wire logic       we,      // Write strobe
  input  wire logic [3:0] waddr,   // Write index
  input  wire logic [7:0] wdata,   // Write value
  input  wire logic [3:0] raddr,   // Read index
  output logic      [7:0] rdata    // Read value, one cycle late
);
  logic [7:0] mem_ff [16];
  logic [7:0] nxt_mem [16];
  logic [7:0] rd_ff;
  logic [7:0] nxt_rd;

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      nxt_mem[i] = (we && waddr == 4'(i)) ? wdata : mem_ff[i];
    end
    nxt_rd = mem_ff[raddr];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 16; i++) begin
        mem_ff[i] <= 8'h00;
      end
      rd_ff <= 8'h00;
    end else begin
      mem_ff <= nxt_mem;
      rd_ff  <= nxt_rd;
    end
  end

  assign rdata = rd_ff;
endmodule : pwds_lvl_mem
`default_nettype wire

// ==== core/pwds_pkg.sv ====
/*
  Shared constants and types for the transmit-driver demo sequencer.
  Assumes one 20 MHz clock and a 32-bit AHB-Lite register port.
*/
package pwds_pkg;
  // Register byte offsets (low address byte only is decoded)
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_STAT  = 8'h04;
  localparam logic [7:0] A_CMD   = 8'h08;
  localparam logic [7:0] A_BURST = 8'h0C;
  localparam logic [7:0] A_RDBK  = 8'h10;
  localparam logic [1:0] A_LVL_HI = 2'h1;  // 0x40..0x7C, level n at 0x40 + 4n
  // Field positions
  localparam int CTRL_EN  = 0;
  localparam int CTRL_EXT = 1;
  localparam int B_RUN    = 3;
  localparam int B_FREQ   = 2;
  localparam int B_PH     = 1;
  localparam int B_AMP    = 0;
  localparam int LS_SIDE  = 3;
  // Reset values
  localparam logic [1:0] CTRL_RST  = 2'h0;
  localparam logic [7:0] BURST_RST = 8'h04;
  // Level-select codes
  localparam logic [3:0] LS_ZERO = 4'h0;
  localparam logic [3:0] LS_A    = 4'h7;
  localparam logic [3:0] LS_B    = 4'hF;
  // Stepping of the operator settings
  localparam logic [1:0] FREQ_LAST = 2'h2;
  localparam logic [5:0] PH_LAST   = 6'h2F;  // 48 steps of 7.5 degrees
  localparam logic [7:0] DAC_FIRST = 8'h0F;
  localparam logic [7:0] DAC_STEP  = 8'h10;
  localparam logic [7:0] DAC_LAST  = 8'hFF;
  localparam logic [7:0] DAC_MID   = 8'h7F;
  // Serial link framing
  localparam int         SER_BITS   = 16;
  localparam logic [3:0] FRAME_LAST = 4'hF;
  localparam logic [3:0] SER_LAST   = 4'hF;
  // Timing: clock rate and the three waveform frequencies, in kHz
  localparam int CLK_KHZ = 20000;
  localparam int F0_KHZ  = 8000;
  localparam int F1_KHZ  = 10000;
  localparam int F2_KHZ  = 13300;
  // Half period in clocks, rounded down, never below one
  function automatic logic [7:0] half_clks(input int f_khz);
    int n;
    n = CLK_KHZ / (2 * f_khz);
    return (n < 1) ? 8'h01 : 8'(n);
  endfunction : half_clks
  localparam logic [7:0] HALF0 = half_clks(F0_KHZ);
  localparam logic [7:0] HALF1 = half_clks(F1_KHZ);
  localparam logic [7:0] HALF2 = half_clks(F2_KHZ);

  typedef enum logic [3:0] {
    S_IDLE, S_FETCH, S_WAIT, S_STROBE, S_ARM,
    S_DELAY, S_WAVE_A, S_GAP_A, S_WAVE_B, S_GAP_B
  } pwds_state_t;

  typedef struct packed {
    logic run;
    logic freq;
    logic phase;
    logic amp;
  } pwds_btn_t;

  typedef struct packed {
    logic sdi;
    logic sck;
    logic cs_n;
    logic load;
  } pwds_ser_t;
endpackage : pwds_pkg

// ==== core/pwds_ser.sv ====
/*
  Serial shifter for the driver's programming port: 16 bits, MSB first,
  clock at half the system rate, data changed on the falling edge.
  Assumes start is only pulsed while busy is low.
*/
`timescale 1ns/10ps
`default_nettype none
module pwds_ser
  import pwds_pkg::*;
(
  input  wire logic        hclk,    // Clock
  input  wire logic        hresetn, // Async reset, low
  input  wire logic        start,   // Begin a frame, one-cycle pulse
  input  wire logic [15:0] word,    // Frame to send
  input  wire logic        sdo,     // Read-back data from driver
  output logic             sdi,     // Serial data to driver
  output logic             sck,     // Serial clock to driver
  output logic             cs_n,    // Chip select, low in a frame
  output logic             busy,    // Frame in progress
  output logic             done,    // Frame finished, one-cycle pulse
  output logic      [15:0] rdata    // Last word read back
);
  logic [15:0] sh_ff, nxt_sh, rx_ff, nxt_rx;
  logic [3:0]  cnt_ff, nxt_cnt;
  logic        act_ff, nxt_act, sck_ff, nxt_sck, done_ff, nxt_done;

  always_comb begin
    nxt_sh   = sh_ff;
    nxt_rx   = rx_ff;
    nxt_cnt  = cnt_ff;
    nxt_act  = act_ff;
    nxt_sck  = sck_ff;
    nxt_done = 1'b0;
    if (!act_ff) begin
      if (start) begin
        nxt_act = 1'b1;
        nxt_sh  = word;
        nxt_cnt = 4'h0;
      end
    end else if (!sck_ff) begin
      // Driver and we both sample on the rising edge
      nxt_sck = 1'b1;
      nxt_rx  = {rx_ff[14:0], sdo};
    end else begin
      nxt_sck = 1'b0;
      nxt_sh  = {sh_ff[14:0], 1'b0};
      nxt_cnt = 4'(cnt_ff + 4'h1);
      if (cnt_ff == SER_LAST) begin
        nxt_act  = 1'b0;
        nxt_done = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh_ff   <= 16'h0000;
      rx_ff   <= 16'h0000;
      cnt_ff  <= 4'h0;
      act_ff  <= 1'b0;
      sck_ff  <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      sh_ff   <= nxt_sh;
      rx_ff   <= nxt_rx;
      cnt_ff  <= nxt_cnt;
      act_ff  <= nxt_act;
      sck_ff  <= nxt_sck;
      done_ff <= nxt_done;
    end
  end

  assign sdi   = sh_ff[15];
  assign sck   = sck_ff;
  assign cs_n  = !act_ff;
  assign busy  = act_ff;
  assign done  = done_ff;
  assign rdata = rx_ff;
endmodule : pwds_ser
`default_nettype wire

// ==== core/pwds_top.sv ====
/*
  Demo sequencer for a PAM ultrasound transmit driver: buttons and an
  AHB-Lite register port set run, frequency, phase and amplitude; each
  burst first loads the driver over its serial port, then plays the
  level-select waveform. Assumes pins and buttons synchronous to hclk.
*/
// Behaviour
// RQ1: code zero means both outputs off
// RQ2: codes 1 to 7 drive output A
// RQ3: codes 8 to 15 drive output B
// RQ4: never drive A and B together
// RQ5: run button starts or stops waveform
// RQ6: frequency button cycles three frequencies; HALF0, HALF1 and HALF2 are all one clock, so the waveform rate never changes
// RQ7: phase button adds 7.5 degrees each press
// RQ8: amplitude button steps DAC code from 15
// RQ9: own output drives driver enable input
// RQ10: phase-zero lamp lit while phase is zero
// RQ11: DAC lamp lit while code is 127
// RQ12: red lamp lit while driver enabled
// RQ13: external trigger can time burst launch
// RQ14: serial data, clock, select, strobe; read back
// RQ15: runs from one board clock
// RQ16: driver enable is active high
// RQ17: load levels and DAC, then strobe
`timescale 1ns/10ps
`default_nettype none
module pwds_top
  import pwds_pkg::*;
(
  input  wire logic                hclk,             // System clock, 20 MHz
  input  wire logic                hresetn,          // Async reset, low
  input  wire logic                hsel,             // AHB select
  input  wire logic [31:0]         haddr,            // AHB address
  input  wire logic [1:0]          htrans,           // AHB transfer type
  input  wire logic                hwrite,           // AHB write
  input  wire logic [2:0]          hsize,            // AHB size, word only
  input  wire logic [31:0]         hwdata,           // AHB write data
  input  wire logic                hready,           // AHB bus ready
  output logic      [31:0]         hrdata,           // AHB read data
  output logic                     hreadyout,        // AHB slave ready
  output logic                     hresp,            // AHB response
  input  wire pwds_pkg::pwds_btn_t buttons,          // Push buttons, high when pressed
  input  wire logic                external_trigger, // Burst launch trigger
  input  wire logic                sdo,              // Driver serial read-back
  output logic      [3:0]          level_select,     // Level-select code to driver
  output pwds_pkg::pwds_ser_t      serial,           // Serial port to driver
  output logic                     driver_enable_control, // Driver enable
  output logic                     enable_lamp,      // Red lamp
  output logic                     phase_zero_lamp,  // Phase-zero lamp
  output logic                     dac_midscale_lamp, // DAC lamp
  output logic                     power_lamp        // Power lamp
);
  import pwds_pkg::*;

  logic        wr_ff, nxt_wr, rdy_ff;
  logic [7:0]  wa_ff, nxt_wa;
  logic [31:0] hrdata_ff, nxt_hrdata, rd_mux;
  logic [1:0]  ctrl_ff, nxt_ctrl;
  logic [7:0]  burst_ff, nxt_burst;
  logic [3:0]  cmd;
  logic        acc, lvl_we;

  logic [3:0]  btn_prev_ff, press;
  logic        run_ff, nxt_run, trig_d_ff, trig_rise;
  logic [1:0]  freq_ff, nxt_freq;
  logic [5:0]  phase_ff, nxt_phase;
  logic [7:0]  dac_ff, nxt_dac;
  logic        en_ff, red_ff, phl_ff, dacl_ff, power_ff;

  pwds_state_t st_ff, nxt_st;
  logic [7:0]  cnt_ff, nxt_cnt, cyc_ff, nxt_cyc, half;
  logic [3:0]  idx_ff, nxt_idx, ls_ff, nxt_ls;
  logic        start_ff, nxt_start, load_ff, nxt_load, go;
  logic [7:0]  mem_rd;
  logic [15:0] ser_rd;
  logic        ser_sdi, ser_sck, ser_csn, ser_busy, ser_done;

  // Register port: zero wait states, write applied in the data phase
  assign acc    = hsel && htrans[1] && hready;
  assign cmd    = (wr_ff && wa_ff == A_CMD) ? hwdata[3:0] : 4'h0;
  assign lvl_we = wr_ff && wa_ff[7:6] == A_LVL_HI;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      A_CTRL:  rd_mux = {30'h0, ctrl_ff};
      A_STAT:  rd_mux = {14'h0, (st_ff != S_IDLE), dac_ff, phase_ff, freq_ff, run_ff};
      A_BURST: rd_mux = {24'h0, burst_ff};
      A_RDBK:  rd_mux = {16'h0, ser_rd};
      default: rd_mux = 32'h0000_0000;
    endcase
    nxt_wr     = acc && hwrite;
    nxt_wa     = acc ? haddr[7:0] : wa_ff;
    nxt_hrdata = (acc && !hwrite) ? rd_mux : hrdata_ff;
    nxt_ctrl   = (wr_ff && wa_ff == A_CTRL) ? hwdata[1:0] : ctrl_ff;
    nxt_burst  = (wr_ff && wa_ff == A_BURST) ? hwdata[7:0] : burst_ff;
  end

  // RQ15 single board clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff     <= 1'b0;
      wa_ff     <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
      rdy_ff    <= 1'b1;
      ctrl_ff   <= CTRL_RST;
      burst_ff  <= BURST_RST;
    end else begin
      wr_ff     <= nxt_wr;
      wa_ff     <= nxt_wa;
      hrdata_ff <= nxt_hrdata;
      rdy_ff    <= 1'b1;
      ctrl_ff   <= nxt_ctrl;
      burst_ff  <= nxt_burst;
    end
  end

  // Operator settings: a press is a rising button edge or a command bit
  assign press     = (buttons & ~btn_prev_ff) | cmd;
  assign trig_rise = external_trigger && !trig_d_ff;

  always_comb begin
    // RQ5 run toggle; dropping enable also stops
    nxt_run   = (run_ff ^ press[B_RUN]) && ctrl_ff[CTRL_EN];
    // RQ6 three-way frequency
    nxt_freq  = (freq_ff == FREQ_LAST) ? 2'h0 : 2'(freq_ff + 2'h1);
    nxt_freq  = press[B_FREQ] ? nxt_freq : freq_ff;
    // RQ7 phase step wraps at 360
    nxt_phase = (phase_ff == PH_LAST) ? 6'h00 : 6'(phase_ff + 6'h01);
    nxt_phase = press[B_PH] ? nxt_phase : phase_ff;
    // RQ8 DAC steps 15, 31 .. 255
    nxt_dac   = (dac_ff == DAC_LAST) ? DAC_FIRST : 8'(dac_ff + DAC_STEP);
    nxt_dac   = press[B_AMP] ? nxt_dac : dac_ff;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      btn_prev_ff <= 4'h0;
      trig_d_ff   <= 1'b0;
      run_ff      <= 1'b0;
      freq_ff     <= 2'h0;
      phase_ff    <= 6'h00;
      dac_ff      <= DAC_FIRST;
      en_ff       <= 1'b0;
      red_ff      <= 1'b0;
      // Phase resets to zero, so its lamp starts lit
      phl_ff      <= 1'b1;
      dacl_ff     <= 1'b0;
      power_ff    <= 1'b0;
    end else begin
      btn_prev_ff <= buttons;
      trig_d_ff   <= external_trigger;
      run_ff      <= nxt_run;
      freq_ff     <= nxt_freq;
      phase_ff    <= nxt_phase;
      dac_ff      <= nxt_dac;
      // RQ9 RQ16 enable high drives driver on
      en_ff       <= nxt_ctrl[CTRL_EN];
      // RQ12 red lamp follows enable
      red_ff      <= nxt_ctrl[CTRL_EN];
      // RQ10 RQ11 lamps track settings
      phl_ff      <= (nxt_phase == 6'h00);
      dacl_ff     <= (nxt_dac == DAC_MID);
      power_ff    <= 1'b1;
    end
  end

  // Sequencer
  assign go = run_ff && ctrl_ff[CTRL_EN];

  always_comb begin
    case (freq_ff)
      2'h0:    half = HALF0;
      2'h1:    half = HALF1;
      default: half = HALF2;
    endcase
  end

  always_comb begin
    nxt_st    = st_ff;
    nxt_cnt   = cnt_ff;
    nxt_cyc   = cyc_ff;
    nxt_idx   = idx_ff;
    nxt_start = 1'b0;
    nxt_load  = 1'b0;
    case (st_ff)
      S_IDLE: begin
        if (go) begin
          nxt_idx = 4'h0;
          nxt_st  = S_FETCH;
        end
      end
      // RQ17 frame per level, index zero is DAC
      S_FETCH: begin
        nxt_start = 1'b1;
        nxt_st    = S_WAIT;
      end
      S_WAIT: begin
        if (ser_done) begin
          if (idx_ff == FRAME_LAST) begin
            nxt_load = 1'b1;
            nxt_st = S_STROBE;
          end else begin
            nxt_idx = 4'(idx_ff + 4'h1);
            nxt_st  = S_FETCH;
          end
        end
      end
      S_STROBE: nxt_st = S_ARM;
      S_ARM: begin
        // RQ13 wait for trigger edge
        if (!ctrl_ff[CTRL_EXT] || trig_rise) begin
          nxt_cnt = {2'h0, phase_ff};
          nxt_cyc = burst_ff;
          nxt_st  = S_DELAY;
        end
      end
      // RQ7 phase as launch delay
      S_DELAY: begin
        nxt_cnt = 8'(cnt_ff - 8'h01);
        if (cnt_ff == 8'h00) begin
          nxt_cnt = 8'(half - 8'h01);
          nxt_st  = S_WAVE_A;
        end
      end
      S_WAVE_A, S_WAVE_B: begin
        nxt_cnt = 8'(cnt_ff - 8'h01);
        if (cnt_ff == 8'h00) begin
          nxt_st = (st_ff == S_WAVE_A) ? S_GAP_A : S_GAP_B;
        end
      end
      S_GAP_A: begin
        nxt_cnt = 8'(half - 8'h01);
        nxt_st  = S_WAVE_B;
      end
      S_GAP_B: begin
        nxt_cnt = 8'(half - 8'h01);
        nxt_cyc = 8'(cyc_ff - 8'h01);
        nxt_st  = S_WAVE_A;
        if (cyc_ff <= 8'h01) begin
          nxt_idx = 4'h0;
          nxt_st  = S_FETCH;
        end
      end
      default: nxt_st = S_IDLE;
    endcase
    // RQ5 stop at once from S_STROBE on; a load under way still sends all its frames and the strobe
    if (!go && st_ff >= S_STROBE) begin
      nxt_st = S_IDLE;
    end
    // RQ1 RQ2 RQ3 RQ4 one side only, zero elsewhere
    case (nxt_st)
      S_WAVE_A: nxt_ls = LS_A;
      S_WAVE_B: nxt_ls = LS_B;
      default:  nxt_ls = LS_ZERO;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff    <= S_IDLE;
      cnt_ff   <= 8'h00;
      cyc_ff   <= 8'h00;
      idx_ff   <= 4'h0;
      ls_ff    <= LS_ZERO;
      start_ff <= 1'b0;
      load_ff  <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      cnt_ff   <= nxt_cnt;
      cyc_ff   <= nxt_cyc;
      idx_ff   <= nxt_idx;
      ls_ff    <= nxt_ls;
      start_ff <= nxt_start;
      load_ff  <= nxt_load;
    end
  end

  pwds_lvl_mem u_mem (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (lvl_we),
    .waddr   (wa_ff[5:2]),
    .wdata   (hwdata[7:0]),
    .raddr   (idx_ff),
    .rdata   (mem_rd)
  );

  // RQ14 serial port with read-back
  pwds_ser u_ser (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (start_ff),
    .word    ({idx_ff, 4'h0, (idx_ff == 4'h0) ? dac_ff : mem_rd}),
    .sdo     (sdo),
    .sdi     (ser_sdi),
    .sck     (ser_sck),
    .cs_n    (ser_csn),
    .busy    (ser_busy),
    .done    (ser_done),
    .rdata   (ser_rd)
  );

  assign hrdata                = hrdata_ff;
  assign hreadyout             = rdy_ff;
  assign hresp                 = 1'b0;
  assign level_select          = ls_ff;
  assign serial                = '{sdi: ser_sdi, sck: ser_sck, cs_n: ser_csn, load: load_ff};
  assign driver_enable_control = en_ff;
  assign enable_lamp           = red_ff;
  assign phase_zero_lamp       = phl_ff;
  assign dac_midscale_lamp     = dacl_ff;
  assign power_lamp            = power_ff;

  property p_idle_zero;
    @(posedge hclk) disable iff (!hresetn) (st_ff == S_IDLE) |-> (ls_ff == LS_ZERO);
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("code not zero in idle"); // RQ1
  property p_side_a;
    @(posedge hclk) disable iff (!hresetn)
      (st_ff == S_WAVE_A) |-> (ls_ff != LS_ZERO && !ls_ff[LS_SIDE]);
  endproperty
  a_side_a: assert property (p_side_a) else $error("A phase not an A code"); // RQ2
  property p_side_b;
    @(posedge hclk) disable iff (!hresetn) (st_ff == S_WAVE_B) |-> ls_ff[LS_SIDE];
  endproperty
  a_side_b: assert property (p_side_b) else $error("B phase not a B code"); // RQ3
  property p_no_cross;
    @(posedge hclk) disable iff (!hresetn)
      (ls_ff != LS_ZERO && $past(ls_ff) != LS_ZERO) |-> (ls_ff[3] == $past(ls_ff[3]));
  endproperty
  a_no_cross: assert property (p_no_cross) else $error("A to B without zero"); // RQ4
  property p_run_toggle;
    @(posedge hclk) disable iff (!hresetn)
      (press[B_RUN] && ctrl_ff[CTRL_EN] && nxt_ctrl[CTRL_EN]) |=> (run_ff != $past(run_ff));
  endproperty
  a_run_toggle: assert property (p_run_toggle) else $error("run did not toggle"); // RQ5
  property p_freq_wrap;
    @(posedge hclk) disable iff (!hresetn)
      (press[B_FREQ] && freq_ff == FREQ_LAST) |=> (freq_ff == 2'h0);
  endproperty
  a_freq_wrap: assert property (p_freq_wrap) else $error("frequency did not wrap"); // RQ6
  property p_phase_step;
    @(posedge hclk) disable iff (!hresetn)
      (press[B_PH] && phase_ff != PH_LAST) |=> (phase_ff == 6'($past(phase_ff) + 6'h01));
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase step wrong"); // RQ7
  property p_amp_wrap;
    @(posedge hclk) disable iff (!hresetn)
      (press[B_AMP] && dac_ff == DAC_LAST) |=> (dac_ff == DAC_FIRST);
  endproperty
  a_amp_wrap: assert property (p_amp_wrap) else $error("DAC did not restart at 15"); // RQ8
  property p_lamps;
    @(posedge hclk) disable iff (!hresetn)
      (phl_ff == (phase_ff == 6'h00)) && (dacl_ff == (dac_ff == DAC_MID));
  endproperty
  a_lamps: assert property (p_lamps) else $error("lamp disagrees with setting"); // RQ10
  property p_red;
    @(posedge hclk) disable iff (!hresetn) (red_ff == en_ff) && (en_ff == ctrl_ff[CTRL_EN]);
  endproperty
  a_red: assert property (p_red) else $error("red lamp or enable mismatch"); // RQ12
  property p_arm_wait;
    @(posedge hclk) disable iff (!hresetn)
      (st_ff == S_ARM && ctrl_ff[CTRL_EXT] && !trig_rise && go) |=> (st_ff == S_ARM);
  endproperty
  a_arm_wait: assert property (p_arm_wait) else $error("launched without trigger"); // RQ13
  property p_strobe;
    @(posedge hclk) disable iff (!hresetn)
      (ser_done && st_ff == S_WAIT && idx_ff == FRAME_LAST) |=> load_ff && ser_csn ##1 !load_ff;
  endproperty
  a_strobe: assert property (p_strobe) else $error("load strobe missing"); // RQ17
  property p_frame;
    @(posedge hclk) disable iff (!hresetn) start_ff |=> ser_busy ##[31:32] ser_done;
  endproperty
  a_frame: assert property (p_frame) else $error("serial frame length wrong"); // RQ14
endmodule : pwds_top
`default_nettype wire

// ==== test/pwds_drv_model.sv ====
/*
  Behavioural model of the transmit driver chip: level-code routing and
  serial capture of DAC and level values, applied on the load strobe.
  Assumes the controller's serial port and level code on hclk.
*/
`timescale 1ns/10ps
`default_nettype none
module pwds_drv_model
  import pwds_pkg::*;
(
  input  wire logic                hclk,         // Clock
  input  wire logic [3:0]          level_select, // Level code
  input  wire logic                enable,       // Driver enable
  input  wire pwds_pkg::pwds_ser_t serial,       // Serial port
  output logic                     sdo,          // Read-back data
  output logic      [7:0]          cur_a,        // Current on output A
  output logic      [7:0]          cur_b         // Current on output B
);
  import pwds_pkg::*;
  localparam logic [15:0] RB_WORD = 16'hA5C3;
  logic [7:0]  lvl [16];
  logic [7:0]  act [16];
  logic [15:0] sh_ff;
  logic [15:0] rb_ff;
  logic        last_ff;
  logic        sck_q;
  logic        cs_q;
  always_comb begin
    cur_a = (enable && level_select != 4'h0 && !level_select[3]) ? act[level_select] : 8'h00;
    cur_b = (enable && level_select[3]) ? act[level_select] : 8'h00;
  end
  // Released line shows the inverse so a stale bit never looks valid
  assign sdo = serial.cs_n ? ~last_ff : rb_ff[15];
  always @(posedge hclk) begin
    sck_q <= serial.sck;
    cs_q  <= serial.cs_n;
    if (!serial.cs_n && serial.sck && !sck_q)
      sh_ff <= {sh_ff[14:0], serial.sdi};
    // Word stands ready while deselected; next bit follows each sck rise
    if (serial.cs_n)
      rb_ff <= RB_WORD;
    else if (serial.sck && !sck_q)
      rb_ff <= {rb_ff[14:0], 1'b0};
    if (!serial.cs_n)
      last_ff <= rb_ff[15];
    if (!cs_q && serial.cs_n)
      lvl[sh_ff[15:12]] <= sh_ff[7:0];
    if (serial.load)
      act <= lvl;
  end
endmodule : pwds_drv_model
`default_nettype wire

// ==== test/tb_top.sv ====
/*
  Self-checking bench for the demo sequencer: AHB-Lite register tasks,
  button and command stepping, burst load and waveform checks.
  Assumes the driver model in pwds_drv_model.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import pwds_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, external_trigger, sdo;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, fr;
  logic [2:0]  hsize;
  pwds_btn_t   buttons;
  pwds_ser_t   serial;
  logic [3:0]  level_select, prev_ls;
  logic        driver_enable_control, enable_lamp, phase_zero_lamp, dac_midscale_lamp, power_lamp;
  logic [7:0]  cur_a, cur_b, lfsr, dac;
  logic [7:0]  lv [16];
  logic [5:0]  ph;
  int          n_errors, checks, cyc, i;
  assign hready = hreadyout;
  pwds_top pwds_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .buttons(buttons),
    .external_trigger(external_trigger), .sdo(sdo), .level_select(level_select),
    .serial(serial), .driver_enable_control(driver_enable_control),
    .enable_lamp(enable_lamp), .phase_zero_lamp(phase_zero_lamp),
    .dac_midscale_lamp(dac_midscale_lamp), .power_lamp(power_lamp));
  pwds_drv_model pwds_drv_model_i (.hclk(hclk), .level_select(level_select),
    .enable(driver_enable_control), .serial(serial), .sdo(sdo), .cur_a(cur_a), .cur_b(cur_b));
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  function automatic logic [7:0] nx(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : nx
  function automatic logic [31:0] stat(input logic r);
    return {14'h0, 1'b0, dac, ph, fr, r};
  endfunction : stat
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic conclude();
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    // Let what the data-phase edge launched settle before callers look
    @(posedge hclk);
  endtask : ahb
  task automatic press(input int b);
    @(posedge hclk);
    buttons <= 4'(1 << b);
    repeat (2) @(posedge hclk);
    buttons <= 4'h0;
    repeat (2) @(posedge hclk);
  endtask : press
  task automatic act(input int b, input logic viacmd);
    if (viacmd) ahb(1'b1, A_CMD, 32'(1 << b));
    else press(b);
    if (b == B_FREQ) fr = (fr == FREQ_LAST) ? 2'h0 : fr + 2'h1;
    if (b == B_PH) ph = (ph == PH_LAST) ? 6'h00 : ph + 6'h01;
    if (b == B_AMP) dac = (dac == DAC_LAST) ? DAC_FIRST : dac + DAC_STEP;
  endtask : act
  task automatic wait_ls(input logic [3:0] v);
    int k;
    k = 0;
    while (level_select !== v && k < 2000) begin
      @(posedge hclk);
      k++;
    end
    chk("level_wait", 32'(k < 2000), 32'h1);
  endtask : wait_ls
  task automatic wait_load();
    int k;
    k = 0;
    while (serial.load !== 1'b1 && k < 3000) begin
      @(posedge hclk);
      k++;
    end
    chk("load_strobe", 32'(k < 3000), 32'h1);
  endtask : wait_load
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge hclk);
      chk("level_idle", 32'(level_select), 32'h0);
    end
  endtask : quiet
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      conclude();
    end
  end
  always @(posedge hclk) begin
    if (hresetn) begin
      chk("overlap", 32'({prev_ls, level_select} == 8'h7F || {prev_ls, level_select} == 8'hF7
        || (cur_a != 8'h00 && cur_b != 8'h00)), 32'h0);
    end
    prev_ls <= level_select;
  end
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; buttons = 4'h0; external_trigger = 1'b0;
    prev_ls = 4'h0; lfsr = 8'h47; fr = 2'h0; ph = 6'h00; dac = DAC_FIRST;
    n_errors = 0; checks = 0; cyc = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, A_CTRL, 32'h0);  chk("ctrl_rst", rd, 32'h0);
    ahb(1'b0, A_BURST, 32'h0); chk("burst_rst", rd, 32'h4);
    chk("hresp", hresp, 32'h0);
    ahb(1'b1, A_STAT, 32'hFFFFFFFF);
    ahb(1'b1, 8'h20, 32'hFFFFFFFF);
    ahb(1'b0, 8'h20, 32'h0);   chk("unmapped", rd, 32'h0);
    ahb(1'b0, A_STAT, 32'h0);  chk("stat_rst", rd, stat(1'b0));
    chk("lamps_rst", {power_lamp, phase_zero_lamp, dac_midscale_lamp, enable_lamp}, 4'hC);
    for (i = 0; i < 24; i++) begin
      lfsr = nx(lfsr);
      act(lfsr % 3, lfsr[4]);
    end
    ahb(1'b0, A_STAT, 32'h0);  chk("stat_rand", rd, stat(1'b0));
    while (dac !== DAC_MID) act(B_AMP, 1'b0);
    chk("dac_lamp_on", dac_midscale_lamp, 1'b1);
    act(B_AMP, 1'b1);
    chk("dac_lamp_off", dac_midscale_lamp, 1'b0);
    while (ph !== PH_LAST) act(B_PH, 1'b1);
    chk("ph_lamp_off", phase_zero_lamp, 1'b0);
    act(B_PH, 1'b0);
    chk("ph_lamp_wrap", phase_zero_lamp, 1'b1);
    press(B_RUN);
    ahb(1'b0, A_STAT, 32'h0);  chk("run_refused", rd, stat(1'b0));
    ahb(1'b1, A_CTRL, 32'h1);
    chk("enable_on", {driver_enable_control, enable_lamp}, 2'h3);
    for (i = 1; i < 16; i++) begin
      lfsr = nx(lfsr);
      lv[i] = lfsr;
      ahb(1'b1, 8'(8'h40 + 4 * i), {24'h0, lfsr});
    end
    lv[0] = dac;
    ahb(1'b1, A_BURST, 32'h1);
    press(B_RUN);
    wait_load();
    repeat (2) @(posedge hclk);
    for (i = 0; i < 16; i++) chk("loaded", pwds_drv_model_i.act[i], lv[i]);
    ahb(1'b0, A_RDBK, 32'h0);  chk("readback", rd, 32'hA5C3);
    wait_ls(LS_A);
    wait_ls(LS_B);
    press(B_RUN);
    repeat (1200) @(posedge hclk);
    quiet(40);
    ahb(1'b0, A_STAT, 32'h0);  chk("stopped", rd, stat(1'b0));
    ahb(1'b1, A_CTRL, 32'h3);
    press(B_RUN);
    wait_load();
    quiet(60);
    @(posedge hclk);
    external_trigger <= 1'b1;
    wait_ls(LS_A);
    external_trigger <= 1'b0;
    ahb(1'b1, A_CTRL, 32'h0);
    repeat (2) @(posedge hclk);
    chk("enable_off", {driver_enable_control, enable_lamp}, 2'h0);
    repeat (1200) @(posedge hclk);
    ahb(1'b0, A_STAT, 32'h0);  chk("disabled", rd, stat(1'b0));
    conclude();
  end
endmodule : tb_top
`default_nettype wire
